// ===== logic/ocfm_monitor.sv
// Overcurrent fault monitor: peak and average fault detection, sticky flags,
// alert, hiccup/latch-off shutdown control and loop reference selection.
// Assumes analog comparators and loop amplifiers outside; pins arrive async.
`timescale 1ns/10ps
`include "ocfm_defs.svh"

module ocfm_monitor (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic enable_pin,
	input wire logic soft_start_done,
	input wire logic switch_cycle,
	input wire ocfm_pkg::ocfm_cmp_t cmp_in,
	input wire ocfm_pkg::ocfm_cmd_t cmd_in,
	output logic [7:0] cmd_rdata,
	output logic cmd_rvalid,
	output logic alert_out_n,
	output logic pwm_enable,
	output logic soft_start_run,
	output logic current_loop_active,
	output logic latched_off,
	output logic [2:0] current_loop_reference,
	output logic [2:0] average_overcurrent_threshold
);
	import ocfm_pkg::*;

	// ********************************
	// Input synchronisers
	// ********************************
	logic [6:0] sync1_q;
	logic [6:0] sync2_q;
	logic cycle_prev_q;
	logic en_prev_q;
	logic phase0_trip;
	logic phase1_trip;
	logic avg_over;
	logic cc_reached;
	logic enable_s;
	logic ss_done_s;
	logic cycle_s;
	logic cycle_pulse;
	logic enable_fall;

	// Two stages for every pin; only the second stage is read
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			sync1_q <= 7'h00;
			sync2_q <= 7'h00;
		end else begin
			sync1_q <= {cmp_in.phase0_trip, cmp_in.phase1_trip, cmp_in.avg_over,
				cmp_in.cc_reached, enable_pin, soft_start_done, switch_cycle};
			sync2_q <= sync1_q;
		end
	end

	assign {phase0_trip, phase1_trip, avg_over, cc_reached, enable_s, ss_done_s, cycle_s} = sync2_q;

	// Edge history for the cycle clock and the enable pin
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			cycle_prev_q <= 1'b0;
			en_prev_q <= 1'b0;
		end else begin
			cycle_prev_q <= cycle_s;
			en_prev_q <= enable_s;
		end
	end

	assign cycle_pulse = cycle_s && !cycle_prev_q;
	assign enable_fall = en_prev_q && !enable_s;

	// ********************************
	// Registers
	// ********************************
	ocfm_state_t state_q;
	ocfm_state_t state_d;
	logic [7:0] flags_q;
	logic [7:0] mask_q;
	logic [7:0] reaction_q;
	logic [2:0] cc_ref_q;
	logic [2:0] avg_thr_q;
	logic armed;
	logic peak_event;
	logic avg_event;
	logic [7:0] set_bits;
	logic [7:0] clr_bits;
	logic peak_cause_q;
	logic avg_cause_q;
	logic peak_act;
	logic avg_act;
	logic shut;
	logic go_latch;

	function automatic logic cmd_hit(input ocfm_cmd_t c, input logic [7:0] code);
		cmd_hit = c.wr && c.code == code;
	endfunction

	// Detection live in soft-start and run, not only after soft-start
	assign armed = state_q == OCFM_SOFT || state_q == OCFM_RUN;

	ocfm_peak_counter u_peak (
		.sys_clk(sys_clk),
		.rst_n(rst_n),
		.armed(armed),
		.cycle_pulse(cycle_pulse),
		.trip({phase1_trip, phase0_trip}),
		.peak_event(peak_event)
	);

	// Average fault is a level compare against the selected threshold
	assign avg_event = armed && avg_over;

	// Flag set and clear terms
	always_comb begin
		set_bits = 8'h00;
		set_bits[`OCFM_BIT_PEAK] = peak_event;
		set_bits[`OCFM_BIT_AVG] = avg_event;
		clr_bits = 8'h00;
		if (cmd_hit(cmd_in, `OCFM_CMD_FAULT_FLAGS)) begin
			clr_bits = cmd_in.wdata;
		end
		if (cmd_hit(cmd_in, `OCFM_CMD_CLEAR_FAULTS) || enable_fall) begin
			clr_bits = 8'hFF;
		end
	end

	// Sticky flags; a set in the clearing cycle wins
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			flags_q <= `OCFM_FLAGS_RESET;
		end else begin
			flags_q <= (flags_q & ~clr_bits) | set_bits;
		end
	end

	// Mask and reaction registers
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			mask_q <= `OCFM_MASK_RESET;
			reaction_q <= `OCFM_REACTION_RESET;
		end else begin
			if (cmd_hit(cmd_in, `OCFM_CMD_FAULT_MASK)) begin
				mask_q <= cmd_in.wdata;
			end
			if (cmd_hit(cmd_in, `OCFM_CMD_FAULT_REACTION)) begin
				reaction_q <= cmd_in.wdata;
			end
		end
	end

	// Threshold selections; only three bits are meaningful
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			cc_ref_q <= `OCFM_CC_REF_RESET;
			avg_thr_q <= `OCFM_AVG_THRESH_RESET;
		end else begin
			if (cmd_hit(cmd_in, `OCFM_CMD_CC_REF)) begin
				cc_ref_q <= cmd_in.wdata[2:0];
			end
			if (cmd_hit(cmd_in, `OCFM_CMD_AVG_THRESH)) begin
				avg_thr_q <= cmd_in.wdata[2:0];
			end
		end
	end

	// Read-back, one cycle after the request
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			cmd_rdata <= 8'h00;
			cmd_rvalid <= 1'b0;
		end else begin
			cmd_rvalid <= cmd_in.rd;
			if (cmd_in.rd) begin
				if (cmd_in.code == `OCFM_CMD_FAULT_FLAGS) begin
					cmd_rdata <= flags_q;
				end else if (cmd_in.code == `OCFM_CMD_FAULT_MASK) begin
					cmd_rdata <= mask_q;
				end else if (cmd_in.code == `OCFM_CMD_FAULT_REACTION) begin
					cmd_rdata <= reaction_q;
				end else if (cmd_in.code == `OCFM_CMD_CC_REF) begin
					cmd_rdata <= {5'h00, cc_ref_q};
				end else if (cmd_in.code == `OCFM_CMD_AVG_THRESH) begin
					cmd_rdata <= {5'h00, avg_thr_q};
				end else begin
					cmd_rdata <= 8'h00;
				end
			end
		end
	end

	// ********************************
	// Protection control
	// ********************************
	// Masked faults only report; unmasked ones shut switching down
	assign peak_act = peak_event && !mask_q[`OCFM_BIT_PEAK];
	assign avg_act = avg_event && !mask_q[`OCFM_BIT_AVG];
	assign shut = peak_act || avg_act;
	// Reaction bit set selects latch-off for that fault
	assign go_latch = (peak_act && reaction_q[`OCFM_BIT_PEAK])
		|| (avg_act && reaction_q[`OCFM_BIT_AVG]);

	// Remember which fault caused a hiccup, for the restart condition
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			peak_cause_q <= 1'b0;
			avg_cause_q <= 1'b0;
		end else if (state_q != OCFM_HICCUP) begin
			peak_cause_q <= peak_act;
			avg_cause_q <= avg_act;
		end
	end

	// Controller state; enable low always wins and returns to off
	always_comb begin
		state_d = state_q;
		case (state_q)
			OCFM_OFF: begin
				if (enable_s) begin
					state_d = OCFM_SOFT;
				end
			end
			OCFM_SOFT, OCFM_RUN: begin
				if (shut) begin
					state_d = go_latch ? OCFM_LATCH : OCFM_HICCUP;
				end else if (state_q == OCFM_SOFT && ss_done_s) begin
					state_d = OCFM_RUN;
				end
			end
			OCFM_HICCUP: begin
				// Restart only when every causing condition has gone
				if (!(peak_cause_q && (phase0_trip || phase1_trip))
					&& !(avg_cause_q && avg_over)) begin
					state_d = OCFM_SOFT;
				end
			end
			OCFM_LATCH: begin
				state_d = OCFM_LATCH;
			end
			default: begin
				state_d = OCFM_OFF;
			end
		endcase
		if (!enable_s) begin
			state_d = OCFM_OFF;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			state_q <= OCFM_OFF;
		end else begin
			state_q <= state_d;
		end
	end

	// ********************************
	// Registered outputs
	// ********************************
	// Switching and loop select follow the next state
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			pwm_enable <= 1'b0;
			soft_start_run <= 1'b0;
			latched_off <= 1'b0;
			current_loop_active <= 1'b0;
		end else begin
			pwm_enable <= state_d == OCFM_SOFT || state_d == OCFM_RUN;
			soft_start_run <= state_d == OCFM_SOFT;
			latched_off <= state_d == OCFM_LATCH;
			// Loop runs from soft-start and overrides at reference
			current_loop_active <= (state_d == OCFM_SOFT || state_d == OCFM_RUN)
				&& cc_reached;
		end
	end

	// Alert follows the flags including any set this cycle
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			alert_out_n <= 1'b1;
		end else begin
			alert_out_n <= ~|((flags_q & ~clr_bits) | set_bits);
		end
	end

	// Threshold codes to the reference DACs
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			current_loop_reference <= `OCFM_CC_REF_RESET;
			average_overcurrent_threshold <= `OCFM_AVG_THRESH_RESET;
		end else begin
			current_loop_reference <= cc_ref_q;
			average_overcurrent_threshold <= avg_thr_q;
		end
	end

endmodule

// ===== logic/ocfm_defs.svh
// Constants for the overcurrent fault monitor: command codes, bit positions,
// reset values and counts. Included by the design modules and the port checker.
`ifndef OCFM_DEFS_SVH
`define OCFM_DEFS_SVH

// ********************************
// Command codes
// ********************************
`define OCFM_CMD_CLEAR_FAULTS 8'h03
`define OCFM_CMD_FAULT_FLAGS 8'hD0
`define OCFM_CMD_FAULT_MASK 8'hD1
`define OCFM_CMD_FAULT_REACTION 8'hD2
`define OCFM_CMD_CC_REF 8'hD5
`define OCFM_CMD_AVG_THRESH 8'hD6

// ********************************
// Bit positions and reset values
// ********************************
`define OCFM_BIT_AVG 4
`define OCFM_BIT_PEAK 5
`define OCFM_MASK_RESET 8'h48
`define OCFM_REACTION_RESET 8'h00
`define OCFM_FLAGS_RESET 8'h00
`define OCFM_CC_REF_RESET 3'h7
`define OCFM_AVG_THRESH_RESET 3'h3

// ********************************
// Counts
// ********************************
`define OCFM_PEAK_CYCLES 2'h3

`endif

// ===== logic/ocfm_pkg.sv
// Types shared by the overcurrent fault monitor modules.
// Assumes ocfm_defs.svh is on the include path.
package ocfm_pkg;

	// ********************************
	// Controller states, Gray along off-soft-run-hiccup-latch
	// ********************************
	typedef enum logic [2:0] {
		OCFM_OFF = 3'h0,
		OCFM_SOFT = 3'h1,
		OCFM_RUN = 3'h3,
		OCFM_HICCUP = 3'h2,
		OCFM_LATCH = 3'h6
	} ocfm_state_t;

	// Comparator levels from the analog front end
	typedef struct packed {
		logic phase0_trip;
		logic phase1_trip;
		logic avg_over;
		logic cc_reached;
	} ocfm_cmp_t;

	// Command port request from the PMBus front end
	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] code;
		logic [7:0] wdata;
	} ocfm_cmd_t;

endpackage

// ===== logic/ocfm_peak_counter.sv
// Per-phase consecutive-cycle counter for the peak overcurrent trip.
// Assumes synchronised trip levels and a one-cycle switching-cycle pulse.
`timescale 1ns/10ps
`include "ocfm_defs.svh"

module ocfm_peak_counter (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic armed,
	input wire logic cycle_pulse,
	input wire logic [1:0] trip,
	output logic peak_event
);
	import ocfm_pkg::*;

	logic [1:0] seen_q;
	logic [1:0] cnt_q [2];

	// ********************************
	// Trip capture inside one switching cycle
	// ********************************
	// A trip that lands on the cycle pulse counts for the next cycle
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			seen_q <= 2'h0;
		end else if (!armed || cycle_pulse) begin
			seen_q <= armed ? trip : 2'h0;
		end else begin
			seen_q <= seen_q | trip;
		end
	end

	// ********************************
	// Consecutive counters, one per phase
	// ********************************
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_q[0] <= 2'h0;
			cnt_q[1] <= 2'h0;
		end else begin
			for (int i = 0; i < 2; i++) begin
				if (!armed) begin
					cnt_q[i] <= 2'h0;
				end else if (cycle_pulse) begin
					if (!seen_q[i]) begin
						cnt_q[i] <= 2'h0;
					end else if (cnt_q[i] != `OCFM_PEAK_CYCLES) begin
						cnt_q[i] <= cnt_q[i] + 2'h1;
					end
				end
			end
		end
	end

	// Pulse in the cycle a phase's third tripped cycle ends
	always_comb begin
		peak_event = 1'b0;
		for (int i = 0; i < 2; i++) begin
			if (armed && cycle_pulse && seen_q[i] && cnt_q[i] == (`OCFM_PEAK_CYCLES - 2'h1)) begin
				peak_event = 1'b1;
			end
		end
	end

endmodule

// ===== testbench/ocfm_props.sv
// Port checker for the overcurrent fault monitor, bound to the monitor.
// Assumes one sys_clk domain and rst_n asynchronous, active low.
`timescale 1ns/10ps
`include "ocfm_defs.svh"

module ocfm_props
	import ocfm_pkg::*;
(
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic enable_pin,
	input wire ocfm_pkg::ocfm_cmp_t cmp_in,
	input wire ocfm_pkg::ocfm_cmd_t cmd_in,
	input wire logic [7:0] cmd_rdata,
	input wire logic alert_out_n,
	input wire logic pwm_enable,
	input wire logic current_loop_active,
	input wire logic latched_off,
	input wire logic [2:0] current_loop_reference,
	input wire logic [2:0] average_overcurrent_threshold
);
	logic [5:0] en_low_q;
	logic [3:0] wr_q;
	logic [7:0] trip_q;
	logic [7:0] mask_q;

	// Cause history; deep enough to span the two-stage pin synchronisers
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			en_low_q <= 6'h00;
			wr_q <= 4'h0;
			trip_q <= 8'h00;
		end else begin
			en_low_q <= {en_low_q[4:0], !enable_pin};
			wr_q <= {wr_q[2:0], cmd_in.wr};
			trip_q <= {trip_q[6:0], cmp_in.phase0_trip | cmp_in.phase1_trip | cmp_in.avg_over};
		end
	end

	// Mirror of the mask register
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n)
			mask_q <= `OCFM_MASK_RESET;
		else if (cmd_in.wr && cmd_in.code == `OCFM_CMD_FAULT_MASK)
			mask_q <= cmd_in.wdata;
	end

	// ********************************
	// Properties
	// ********************************
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_n);

	AST_ALERT_WHILE_FLAG: assert property (
		(cmd_in.rd && !cmd_in.wr && cmd_in.code == `OCFM_CMD_FAULT_FLAGS) ##1 (cmd_rdata != 8'h00)
		|-> ##[0:1] !alert_out_n) else $error("alert high with a flag set");
	AST_ALERT_RELEASE: assert property (
		$rose(alert_out_n) |-> (wr_q != 4'h0 || en_low_q != 6'h00)) else $error("flags cleared alone");
	AST_ALERT_CAUSE: assert property (
		$fell(alert_out_n) |-> trip_q != 8'h00) else $error("alert without a trip");
	AST_PWM_STOP_CAUSE: assert property (
		$fell(pwm_enable) |-> en_low_q != 6'h00 || (!alert_out_n && mask_q[5:4] != 2'b11))
		else $error("switching stopped without unmasked fault");
	AST_LATCH_NO_PWM: assert property (
		latched_off |-> !pwm_enable) else $error("switching while latched off");
	AST_LATCH_EXIT: assert property (
		$fell(latched_off) |-> en_low_q != 6'h00) else $error("latch left without enable low");
	AST_CC_REF_WRITE: assert property (
		(cmd_in.wr && cmd_in.code == `OCFM_CMD_CC_REF)
		##1 !(cmd_in.wr && cmd_in.code == `OCFM_CMD_CC_REF) |=>
		current_loop_reference == $past(cmd_in.wdata[2:0], 2)) else $error("reference write lost");
	AST_THRESH_WRITE: assert property (
		(cmd_in.wr && cmd_in.code == `OCFM_CMD_AVG_THRESH)
		##1 !(cmd_in.wr && cmd_in.code == `OCFM_CMD_AVG_THRESH) |=>
		average_overcurrent_threshold == $past(cmd_in.wdata[2:0], 2)) else $error("threshold lost");
	AST_CC_READBACK: assert property (
		cmd_in.rd && !cmd_in.wr && cmd_in.code == `OCFM_CMD_CC_REF |=>
		cmd_rdata == {5'h00, current_loop_reference}) else $error("reference readback");
	AST_LOOP_TAKES_OVER: assert property (
		(pwm_enable && cmp_in.cc_reached) [*5] |-> current_loop_active)
		else $error("current loop idle at reference");

	cover property ($fell(alert_out_n));
	cover property ($rose(latched_off));
	cover property ($rose(current_loop_active));
endmodule

bind ocfm_monitor ocfm_props ocfm_props_i (.sys_clk(sys_clk), .rst_n(rst_n),
	.enable_pin(enable_pin), .cmp_in(cmp_in), .cmd_in(cmd_in), .cmd_rdata(cmd_rdata),
	.alert_out_n(alert_out_n), .pwm_enable(pwm_enable), .current_loop_active(current_loop_active),
	.latched_off(latched_off), .current_loop_reference(current_loop_reference),
	.average_overcurrent_threshold(average_overcurrent_threshold));

// ===== testbench/ocfm_host.sv
// Host model: single-byte commands on the monitor's command port.
// Assumes answers one cycle after the request edge.
`timescale 1ns/10ps

module ocfm_host (
	input wire logic sys_clk,
	input wire logic [7:0] cmd_rdata,
	input wire logic cmd_rvalid,
	output ocfm_pkg::ocfm_cmd_t cmd
);
	import ocfm_pkg::*;

	initial cmd = '0;

	// One request; idle code and data are inverted so stale values are never trusted
	task automatic xfer(input logic w, input logic [7:0] code, input logic [7:0] d,
		output logic [7:0] q);
		@(posedge sys_clk);
		#1 cmd = {w, !w, code, d};
		@(posedge sys_clk);
		// Answer stands from the edge that took the request; read it off that edge
		#1 cmd = {2'b00, ~code, ~d};
		q = cmd_rvalid ? cmd_rdata : 8'hXX;
	endtask
endmodule

// ===== testbench/ocfm_monitor_bench.sv
// Bench for the overcurrent fault monitor: reset values, peak and average
// faults, hiccup, latch, mask and random loop settings.
// Assumes ocfm_host as the command partner and ocfm_props bound to the monitor.
`timescale 1ns/10ps

module ocfm_monitor_bench;
	import ocfm_pkg::*;
	logic sys_clk, rst_n, enable_pin, soft_start_done, switch_cycle;
	ocfm_cmp_t cmp;
	ocfm_cmd_t cmd;
	logic [7:0] cmd_rdata, q, v, c;
	logic cmd_rvalid, alert_out_n, pwm_enable, soft_start_run, current_loop_active, latched_off;
	logic [2:0] current_loop_reference, average_overcurrent_threshold;
	logic [7:0] rcode [6] = '{8'hD0, 8'hD1, 8'hD2, 8'hD5, 8'hD6, 8'h55};
	logic [7:0] rexp [6] = '{8'h00, 8'h48, 8'h00, 8'h07, 8'h03, 8'h00};
	int errors, compares;

	ocfm_monitor ocfm_monitor_i (.sys_clk(sys_clk), .rst_n(rst_n), .enable_pin(enable_pin),
		.soft_start_done(soft_start_done), .switch_cycle(switch_cycle), .cmp_in(cmp),
		.cmd_in(cmd), .cmd_rdata(cmd_rdata), .cmd_rvalid(cmd_rvalid), .alert_out_n(alert_out_n),
		.pwm_enable(pwm_enable), .soft_start_run(soft_start_run),
		.current_loop_active(current_loop_active), .latched_off(latched_off),
		.current_loop_reference(current_loop_reference),
		.average_overcurrent_threshold(average_overcurrent_threshold));
	ocfm_host ocfm_host_i (.sys_clk(sys_clk), .cmd_rdata(cmd_rdata), .cmd_rvalid(cmd_rvalid),
		.cmd(cmd));

	// 100 MHz clock
	initial begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end

	// ********************************
	// Helpers
	// ********************************
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		compares++;
		if (seen !== exp) begin
			errors++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	function automatic logic [7:0] flags(input logic peak, input logic avg);
		return {2'b00, peak, avg, 4'h0};
	endfunction
	task automatic conclude();
		$display("compares=%0d errors=%0d", compares, errors);
		if (errors == 0 && compares > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask
	task automatic rdq(input logic [7:0] a);
		ocfm_host_i.xfer(1'b0, a, 8'h00, q);
	endtask
	task automatic wrq(input logic [7:0] a, input logic [7:0] d);
		ocfm_host_i.xfer(1'b1, a, d, q);
	endtask
	// Switching cycles; trips pulse early in the low phase so each lands in one window
	task automatic swc(input int n, input logic [1:0] t);
		repeat (n) begin
			switch_cycle = 1'b1;
			cyc(3);
			switch_cycle = 1'b0;
			{cmp.phase1_trip, cmp.phase0_trip} = t;
			cyc(2);
			{cmp.phase1_trip, cmp.phase0_trip} = 2'b00;
			cyc(3);
		end
	endtask
	task automatic wait_pwm(input logic e);
		for (int i = 0; i < 80 && pwm_enable !== e; i++)
			cyc(1);
		if (pwm_enable !== e) begin
			check(pwm_enable, e);
			conclude();
		end
	endtask

	// ********************************
	// Main sequence
	// ********************************
	initial begin
		rst_n = 1'b0;
		enable_pin = 1'b0;
		soft_start_done = 1'b0;
		switch_cycle = 1'b0;
		cmp = '0;
		errors = 0;
		compares = 0;
		void'($urandom(96612));
		cyc(8);
		rst_n = 1'b1;
		foreach (rcode[k]) begin
			rdq(rcode[k]);
			check(q, rexp[k]);
		end
		$display("test reset done");
		enable_pin = 1'b1;
		wait_pwm(1'b1);
		check(soft_start_run, 1'b1);
		cmp.cc_reached = 1'b1;
		cyc(6);
		check(current_loop_active, 1'b1);
		cmp.cc_reached = 1'b0;
		$display("test soft-start done");
		// Two tripped cycles, a clean one, then counting starts over
		swc(2, 2'b11);
		swc(1, 2'b00);
		swc(2, 2'b10);
		rdq(8'hD0);
		check(q, flags(1'b0, 1'b0));
		swc(1, 2'b10);
		cmp.phase0_trip = 1'b1;
		switch_cycle = 1'b1;
		cyc(8);
		check({pwm_enable, alert_out_n}, 2'b00);
		rdq(8'hD0);
		check(q, flags(1'b1, 1'b0));
		cmp.phase0_trip = 1'b0;
		switch_cycle = 1'b0;
		wait_pwm(1'b1);
		check({soft_start_run, alert_out_n}, 2'b10);
		wrq(8'hD0, 8'h20);
		check(alert_out_n, 1'b1);
		$display("test peak done");
		soft_start_done = 1'b1;
		cyc(6);
		check({soft_start_run, pwm_enable}, 2'b01);
		cmp.avg_over = 1'b1;
		cyc(6);
		check({pwm_enable, alert_out_n}, 2'b00);
		rdq(8'hD0);
		check(q, flags(1'b0, 1'b1));
		cmp.avg_over = 1'b0;
		wait_pwm(1'b1);
		wrq(8'h03, 8'($urandom));
		rdq(8'hD0);
		check(q, flags(1'b0, 1'b0));
		check(alert_out_n, 1'b1);
		$display("test average done");
		wrq(8'hD2, 8'h30);
		cmp.avg_over = 1'b1;
		cyc(6);
		cmp.avg_over = 1'b0;
		cyc(12);
		check({latched_off, pwm_enable}, 2'b10);
		enable_pin = 1'b0;
		cyc(8);
		check({latched_off, alert_out_n}, 2'b01);
		enable_pin = 1'b1;
		wait_pwm(1'b1);
		$display("test latch done");
		wrq(8'hD1, 8'h78);
		cmp.avg_over = 1'b1;
		cyc(10);
		check({pwm_enable, alert_out_n}, 2'b10);
		cmp.avg_over = 1'b0;
		// Let the synchronised level fall first, or the set beats the clear
		cyc(3);
		wrq(8'hD0, 8'h10);
		check(alert_out_n, 1'b1);
		$display("test mask done");
		repeat (8) begin
			v = 8'($urandom);
			c = v[7] ? 8'hD5 : 8'hD6;
			wrq(c, v);
			rdq(c);
			check(q, {5'h00, v[2:0]});
			check(v[7] ? current_loop_reference : average_overcurrent_threshold, v[2:0]);
		end
		$display("test settings done");
		conclude();
	end
endmodule
